// file: limit_overtravel_logic.sv
/*
  Limit-switch, home-switch and slot-detector handling with over-travel
  alarm, stop requests, home-search reversal and a small register file.
  Assumes the motion controller on the same clock reports whether a
  continuous run or a home search is in progress and obeys motor_stop.
*/
`timescale 1ns/1ps
module limit_overtravel_logic
  import limit_overtravel_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // sensor pins, asynchronous
  input  wire logic              positive_limit_input,
  input  wire logic              negative_limit_input,
  input  wire logic              home_switch_input,
  input  wire logic              slot_detect_input,
  input  wire logic              alarm_clear_input,
  // motion context from the controller
  input  wire logic              continuous_run,
  input  wire logic              home_search_run,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // motion outputs
  output logic                   fault_output,
  output logic                   motor_stop,
  output logic      [1:0]        stop_action,
  output logic                   reverse_req,
  output logic                   reverse_dir,
  output logic                   home_found,
  output logic                   irq
);

  // pin synchroniser: three flops, a change counts once stages two and three agree
  logic [NUM_IN-1:0] sync1_q;
  logic [NUM_IN-1:0] sync2_q;
  logic [NUM_IN-1:0] sync3_q;
  logic [NUM_IN-1:0] filt_q;
  logic [NUM_IN-1:0] filt_d;
  logic [NUM_IN-1:0] pins;

  assign pins = {alarm_clear_input, slot_detect_input, home_switch_input,
                 negative_limit_input, positive_limit_input};

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++)
    begin : g_filt
      assign filt_d[gi] = (sync2_q[gi] == sync3_q[gi]) ? sync3_q[gi] : filt_q[gi];
    end
  endgenerate

  // registers and state
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic [NUM_IN-1:0] prev_q;
  logic [NUM_IN-1:0] act;
  logic              alarm_q;
  logic              alarm_d;
  logic              slot_stop_q;
  logic              slot_stop_d;
  logic [1:0]        action_q;
  logic [1:0]        action_d;
  logic              rev_q;
  logic              rev_d;
  logic              rev_dir_q;
  logic              rev_dir_d;
  logic              home_q;
  logic              home_d;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_stat_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_mask_d;
  logic [IRQ_W-1:0]  irq_set;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              fault_q;
  logic              fault_d;
  logic              stop_q;
  logic              stop_d;
  logic              pos_rise;
  logic              neg_rise;
  logic              home_rise;
  logic              slot_rise;
  logic              clr_rise;
  logic              clear_req;
  logic              ot_trip;
  logic              slot_trip;
  logic              wr_ctrl;
  logic              wr_cmd;
  logic              wr_stat;
  logic              wr_mask;

  // one shared over-travel polarity bit; a set bit means normally closed
  assign act[IN_POS]  = filt_q[IN_POS] ^ ctrl_q[OT_POL_BIT];
  assign act[IN_NEG]  = filt_q[IN_NEG] ^ ctrl_q[OT_POL_BIT];
  assign act[IN_HOME] = filt_q[IN_HOME] ^ ctrl_q[HOME_POL_BIT];
  assign act[IN_SLOT] = filt_q[IN_SLOT] ^ ctrl_q[SLOT_POL_BIT];
  assign act[IN_CLR]  = filt_q[IN_CLR];

  // edges, so a limit still held after a clear does not re-trip at once
  assign pos_rise  = act[IN_POS] & ~prev_q[IN_POS];
  assign neg_rise  = act[IN_NEG] & ~prev_q[IN_NEG];
  assign home_rise = act[IN_HOME] & ~prev_q[IN_HOME];
  assign slot_rise = act[IN_SLOT] & ~prev_q[IN_SLOT];
  assign clr_rise  = act[IN_CLR] & ~prev_q[IN_CLR];

  assign wr_ctrl = reg_write && (reg_addr == CTRL_OFFSET);
  assign wr_cmd  = reg_write && (reg_addr == CMD_OFFSET);
  assign wr_stat = reg_write && (reg_addr == IRQ_STAT_OFFSET);
  assign wr_mask = reg_write && (reg_addr == IRQ_MASK_OFFSET);

  assign clear_req = clr_rise | (wr_cmd & reg_wdata[CMD_CLEAR_BIT]);
  assign ot_trip   = (pos_rise | neg_rise) & ~home_search_run;
  assign slot_trip = slot_rise & continuous_run & ~ctrl_q[SLOT_HOME_BIT];

  always_comb
  begin
    ctrl_d      = wr_ctrl ? reg_wdata[CTRL_W-1:0] : ctrl_q;
    // a trip in the same cycle as a clear keeps the alarm set
    alarm_d     = ot_trip ? 1'b1 : (clear_req ? 1'b0 : alarm_q);
    // slot stop holds until the controller ends the continuous run
    slot_stop_d = slot_trip ? 1'b1 : (continuous_run ? slot_stop_q : 1'b0);
    action_d    = action_q;
    if (ot_trip)
    begin
      action_d = ctrl_q[OT_ACT_LSB +: 2];
    end
    else if (slot_trip)
    begin
      action_d = ctrl_q[SLOT_ACT_LSB +: 2];
    end
    // home search: turn away from the limit that was met, positive limit first
    rev_d     = home_search_run & (pos_rise | neg_rise);
    rev_dir_d = rev_d ? ~pos_rise : rev_dir_q;
    home_d    = home_search_run & (ctrl_q[THREE_SW_BIT] ? home_rise
                                   : (ctrl_q[SLOT_HOME_BIT] & slot_rise));
    fault_d   = ~alarm_d;
    stop_d    = alarm_d | slot_stop_d;
  end

  // interrupt status: hardware set wins over a write-one-to-clear
  always_comb
  begin
    irq_set                = '0;
    irq_set[IRQ_OT_BIT]    = ot_trip;
    irq_set[IRQ_SLOT_BIT]  = slot_trip;
    irq_set[IRQ_HOME_BIT]  = home_d;
    irq_set[IRQ_CLEAR_BIT] = clear_req & alarm_q & ~ot_trip;
    irq_set[IRQ_REV_BIT]   = rev_d;
    irq_stat_d = irq_set | (irq_stat_q & ~(wr_stat ? reg_wdata[IRQ_W-1:0] : '0));
    irq_mask_d = wr_mask ? reg_wdata[IRQ_W-1:0] : irq_mask_q;
  end

  // read data for the cycle after the strobe; unmapped offsets read zero
  always_comb
  begin
    rdata_d = '0;
    if (reg_read)
    begin
      case (reg_addr)
        CTRL_OFFSET:     rdata_d[CTRL_W-1:0] = ctrl_q;
        STATUS_OFFSET:   rdata_d[7:0] = {rev_dir_q, action_q, slot_stop_q, act[IN_SLOT],
                                         act[IN_HOME], act[IN_NEG] | act[IN_POS],
                                         alarm_q};
        IRQ_STAT_OFFSET: rdata_d[IRQ_W-1:0] = irq_stat_q;
        IRQ_MASK_OFFSET: rdata_d[IRQ_W-1:0] = irq_mask_q;
        default:         rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q      <= CTRL_RESET;
      prev_q      <= '0;
      alarm_q     <= 1'b0;
      slot_stop_q <= 1'b0;
      action_q    <= STOP_DECEL;
      rev_q       <= 1'b0;
      rev_dir_q   <= 1'b0;
      home_q      <= 1'b0;
      irq_stat_q  <= '0;
      irq_mask_q  <= '0;
      rdata_q     <= '0;
      fault_q     <= 1'b1;
      stop_q      <= 1'b0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      prev_q      <= act;
      alarm_q     <= alarm_d;
      slot_stop_q <= slot_stop_d;
      action_q    <= action_d;
      rev_q       <= rev_d;
      rev_dir_q   <= rev_dir_d;
      home_q      <= home_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
      rdata_q     <= rdata_d;
      fault_q     <= fault_d;
      stop_q      <= stop_d;
    end
  end

  assign reg_rdata    = rdata_q;
  assign fault_output = fault_q;
  assign motor_stop   = stop_q;
  assign stop_action  = action_q;
  assign reverse_req  = rev_q;
  assign reverse_dir  = rev_dir_q;
  assign home_found   = home_q;
  assign irq          = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  a_trip_stops_motor: assert property (ot_trip |=> alarm_q && !fault_output && motor_stop)
    else $error("over-travel did not stop the motor");
  a_trip_action_sel: assert property (ot_trip
    |=> stop_action == $past(ctrl_q[OT_ACT_LSB +: 2]))
    else $error("over-travel stop action wrong");
  a_clear_drops_alarm: assert property (clear_req && !ot_trip
    |=> !alarm_q && fault_output)
    else $error("alarm clear not honoured");
  a_home_reverses: assert property (home_search_run && (pos_rise || neg_rise)
    && !alarm_q |=> reverse_req && !alarm_q && reverse_dir == !$past(pos_rise))
    else $error("home search limit handling wrong");
  a_home_switch_home: assert property (home_search_run && ctrl_q[THREE_SW_BIT]
    && home_rise |=> home_found)
    else $error("home switch not taken as home");
  a_slot_forced_stop: assert property (slot_trip && !ot_trip
    |=> motor_stop && stop_action == $past(ctrl_q[SLOT_ACT_LSB +: 2]))
    else $error("slot detector stop wrong");
  a_slot_home_idle: assert property (ctrl_q[SLOT_HOME_BIT] && !slot_stop_q
    && !alarm_q && !ot_trip |=> !motor_stop)
    else $error("slot detector used as stop while assigned to home");
  a_limit_polarity: assert property (!ctrl_q[OT_POL_BIT] && $stable(ctrl_q)
    && !home_search_run && !alarm_q && $rose(filt_q[IN_NEG]) |=> alarm_q)
    else $error("normally-open limit not detected");
  a_shared_polarity: assert property (ctrl_q[OT_POL_BIT] && !home_search_run
    && !alarm_q && $fell(filt_q[IN_POS]) && $stable(ctrl_q) |=> alarm_q)
    else $error("shared closed polarity not applied");
  // per bit: only a pin whose stages agreed may move its filtered value
  a_sync_agree: assert property ($changed(filt_q)
    |-> (($past(filt_q) ^ filt_q) & ($past(sync2_q) ^ $past(sync3_q))) == '0)
    else $error("input accepted before stages agreed");

  a_alarm_holds: assert property (alarm_q && !clear_req
    |=> alarm_q && !fault_output)
    else $error("alarm dropped without a clear");
  a_alarm_stops: assert property (alarm_q |-> motor_stop && !fault_output)
    else $error("alarm without motor stop");
  a_irq_set_wins: assert property (ot_trip && wr_stat |=> irq_stat_q[IRQ_OT_BIT])
    else $error("status clear beat an over-travel trip");
  a_action_holds: assert property (!ot_trip && !slot_trip |=> $stable(stop_action))
    else $error("stop action changed without a stop");
  a_pin_clear: assert property (clr_rise && alarm_q && !ot_trip
    |=> !alarm_q && irq_stat_q[IRQ_CLEAR_BIT])
    else $error("alarm-clear pin not honoured");
  a_home_no_alarm: assert property (home_search_run && !alarm_q
    && (pos_rise || neg_rise) |=> !alarm_q && fault_output)
    else $error("home search limit raised an alarm");
  a_three_sw_only: assert property (ctrl_q[THREE_SW_BIT] && !home_rise
    |=> !home_found)
    else $error("home found from a source other than the home switch");
  a_slot_polarity: assert property (ctrl_q[SLOT_POL_BIT] && $stable(ctrl_q)
    && continuous_run && !ctrl_q[SLOT_HOME_BIT] && $fell(filt_q[IN_SLOT]) |=> motor_stop)
    else $error("closed slot detector polarity not applied");
  a_slot_release: assert property (slot_stop_q && !continuous_run
    && !alarm_q && !ot_trip |=> !motor_stop && !slot_stop_q)
    else $error("slot stop outlived the continuous run");
  a_slot_idle_run: assert property (!continuous_run |=> !slot_stop_q)
    else $error("slot stop raised outside continuous run");
  a_neg_shared_pol: assert property (ctrl_q[OT_POL_BIT] && !home_search_run
    && $fell(filt_q[IN_NEG]) && $stable(ctrl_q) |=> alarm_q)
    else $error("shared closed polarity not applied to the negative limit");

endmodule

// file: limit_overtravel_pkg.sv
/*
  Constants for the limit-switch and over-travel logic: register offsets,
  control field positions, reset values, stop-action codes, input indices.
  Assumes a single 40 MHz clock and a plain one-cycle register port.
*/
// Contract
// - The end-of-travel inputs have a polarity set by software, normally open after reset.
// - One polarity bit serves both end-of-travel inputs together.
// - An active end-of-travel input trips over-travel, turns the fault output off and stops the motor.
// - The over-travel stop method comes from a software-written stop-action field.
// - One pulse on the alarm-clear pin or an alarm-clear command cancels over-travel.
// - During a home search a limit reverses the direction away from it and raises no alarm.
// - In three-switch home mode the home switch marks home, with selectable polarity, normally open.
// - The slot-disc detector has a software-selectable polarity, normally open after reset.
// - In continuous run an active slot detector forces a stop with its own stop-action field.
// - A slot detector assigned to home searching is no stop source in continuous run.
// - The alarm-clear pin resets the protective alarm, pulsed once after the cause is gone.
package limit_overtravel_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  // register offsets
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]  CMD_OFFSET    = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET = 8'h08;
  localparam logic [7:0]  IRQ_STAT_OFFSET = 8'h0C;
  localparam logic [7:0]  IRQ_MASK_OFFSET = 8'h10;

  // control register fields
  localparam int          OT_POL_BIT    = 0;
  localparam int          HOME_POL_BIT  = 1;
  localparam int          SLOT_POL_BIT  = 2;
  localparam int          SLOT_HOME_BIT = 3;
  localparam int          THREE_SW_BIT  = 4;
  localparam int          OT_ACT_LSB    = 8;
  localparam int          SLOT_ACT_LSB  = 10;
  localparam int          CTRL_W        = 12;
  localparam logic [11:0] CTRL_RESET    = 12'h000;

  // command register fields
  localparam int          CMD_CLEAR_BIT = 0;

  // stop-action codes
  localparam logic [1:0]  STOP_DECEL    = 2'h0;
  localparam logic [1:0]  STOP_IMMED    = 2'h1;

  // interrupt status / mask bits
  localparam int          IRQ_OT_BIT    = 0;
  localparam int          IRQ_SLOT_BIT  = 1;
  localparam int          IRQ_HOME_BIT  = 2;
  localparam int          IRQ_CLEAR_BIT = 3;
  localparam int          IRQ_REV_BIT   = 4;
  localparam int          IRQ_W         = 5;

  // synchronised pin indices
  localparam int          IN_POS        = 0;
  localparam int          IN_NEG        = 1;
  localparam int          IN_HOME       = 2;
  localparam int          IN_SLOT       = 3;
  localparam int          IN_CLR        = 4;
  localparam int          NUM_IN        = 5;

endpackage

// file: sensor_model.sv
/*
  Far-side model: two end-of-travel switches, a home switch and a slot-disc
  detector, each wired either normally open or normally closed.
  Assumes the bench sets switch states and wiring off the clock edge.
*/
`timescale 1ns/1ps
module sensor_model
(
  // switch states, 1 = actuated
  input  wire logic pos_on,
  input  wire logic neg_on,
  input  wire logic home_on,
  input  wire logic slot_on,
  // wiring, 1 = normally closed contact
  input  wire logic nc_lim,
  input  wire logic nc_home,
  input  wire logic nc_slot,
  // pins toward the block
  output logic      positive_limit_input,
  output logic      negative_limit_input,
  output logic      home_switch_input,
  output logic      slot_detect_input
);
  // a closed contact idles high and opens when actuated
  assign positive_limit_input = pos_on ^ nc_lim;
  assign negative_limit_input = neg_on ^ nc_lim;
  assign home_switch_input    = home_on ^ nc_home;
  assign slot_detect_input    = slot_on ^ nc_slot;
endmodule

// file: tb.sv
/*
  Self-checking bench for the limit and over-travel logic.
  Assumes the design's one-cycle register port and its sensor model partner.
*/
`timescale 1ns/1ps
module tb
  import limit_overtravel_pkg::*;
;
  logic mclk = 1'b0, rstn = 1'b0, alarm_clear_input = 1'b0;
  logic continuous_run = 1'b0, home_search_run = 1'b0;
  logic pos_on = 1'b0, neg_on = 1'b0, home_on = 1'b0, slot_on = 1'b0;
  logic nc_lim = 1'b0, nc_home = 1'b0, nc_slot = 1'b1;
  logic positive_limit_input, negative_limit_input, home_switch_input, slot_detect_input;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic reg_write = 1'b0, reg_read = 1'b0;
  logic fault_output, motor_stop, reverse_req, reverse_dir, home_found, irq;
  logic [1:0] stop_action;
  int bad_count = 0, n_checks = 0;

  always #12.5 mclk = ~mclk;

  sensor_model sens (.pos_on(pos_on), .neg_on(neg_on), .home_on(home_on), .slot_on(slot_on),
    .nc_lim(nc_lim), .nc_home(nc_home), .nc_slot(nc_slot),
    .positive_limit_input(positive_limit_input), .negative_limit_input(negative_limit_input),
    .home_switch_input(home_switch_input), .slot_detect_input(slot_detect_input));

  limit_overtravel_logic dut (.mclk(mclk), .rstn(rstn),
    .positive_limit_input(positive_limit_input), .negative_limit_input(negative_limit_input),
    .home_switch_input(home_switch_input), .slot_detect_input(slot_detect_input),
    .alarm_clear_input(alarm_clear_input), .continuous_run(continuous_run),
    .home_search_run(home_search_run), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .fault_output(fault_output), .motor_stop(motor_stop), .stop_action(stop_action),
    .reverse_req(reverse_req), .reverse_dir(reverse_dir), .home_found(home_found), .irq(irq));

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_word(nm, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    chk_word(nm, exp, reg_rdata);
  endtask

  // sel: 0 fault_output, 1 motor_stop, 2 reverse_req, 3 home_found
  task automatic wait_for(input int sel, input logic v);
    logic s;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge mclk);
      #1;
      s = (sel == 0) ? fault_output : (sel == 1) ? motor_stop : (sel == 2) ? reverse_req : home_found;
      if (s === v)
      begin
        n_checks++;
        return;
      end
    end
    bad_count++;
    $display("[ERR] wait %0d expected %b seen timeout", sel, v);
    results();
  endtask

  initial
  begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    rd(CTRL_OFFSET, 32'h0, "ctrl");
    rd(IRQ_MASK_OFFSET, 32'h0, "mask");
    rd(8'h40, 32'h0, "unmapped");
    chk_bit("fault", 1'b1, fault_output);
    wr(IRQ_MASK_OFFSET, 32'h1F);
    wr(CTRL_OFFSET, 32'h100);
    neg_on <= 1'b1;
    wait_for(0, 1'b0);
    chk_bit("stop", 1'b1, motor_stop);
    chk_word("act", {30'h0, STOP_IMMED}, {30'h0, stop_action});
    chk_bit("irq", 1'b1, irq);
    // slot pin is wired closed but still read open, so it shows active
    rd(STATUS_OFFSET, 32'h2B, "status");
    wr(CMD_OFFSET, 32'h1);
    wait_for(0, 1'b1);
    repeat (8) @(posedge mclk);
    #1;
    chk_bit("fault held", 1'b1, fault_output);
    chk_bit("stop off", 1'b0, motor_stop);
    wr(IRQ_STAT_OFFSET, 32'h1F);
    rd(IRQ_STAT_OFFSET, 32'h0, "irq stat");
    chk_bit("irq off", 1'b0, irq);
    // leave the limit after clearing
    neg_on <= 1'b0;
    // one polarity bit for both limits, wired closed; the swap itself trips once
    wr(IRQ_MASK_OFFSET, 32'h0);
    wr(CTRL_OFFSET, 32'h001);
    nc_lim <= 1'b1;
    repeat (8) @(posedge mclk);
    wr(CMD_OFFSET, 32'h1);
    wr(IRQ_STAT_OFFSET, 32'h1F);
    repeat (8) @(posedge mclk);
    pos_on <= 1'b1;
    wait_for(0, 1'b0);
    chk_word("act decel", {30'h0, STOP_DECEL}, {30'h0, stop_action});
    chk_bit("irq masked", 1'b0, irq);
    alarm_clear_input <= 1'b1;
    repeat (3) @(posedge mclk);
    alarm_clear_input <= 1'b0;
    wait_for(0, 1'b1);
    pos_on <= 1'b0;
    home_search_run <= 1'b1;
    repeat (8) @(posedge mclk);
    pos_on <= 1'b1;
    wait_for(2, 1'b0 ^ 1'b1);
    chk_bit("dir", 1'b0, reverse_dir);
    chk_bit("no alarm", 1'b1, fault_output);
    pos_on <= 1'b0;
    wr(CTRL_OFFSET, 32'h011);
    home_on <= 1'b1;
    wait_for(3, 1'b1);
    home_on <= 1'b0;
    home_search_run <= 1'b0;
    // slot wired closed with its polarity bit set; in continuous run it forces a stop with its own action
    wr(CTRL_OFFSET, 32'h405);
    continuous_run <= 1'b1;
    repeat (8) @(posedge mclk);
    slot_on <= 1'b1;
    wait_for(1, 1'b1);
    chk_word("slot act", {30'h0, STOP_IMMED}, {30'h0, stop_action});
    continuous_run <= 1'b0;
    wait_for(1, 1'b0);
    slot_on <= 1'b0;
    wr(CTRL_OFFSET, 32'h40D);
    continuous_run <= 1'b1;
    repeat (8) @(posedge mclk);
    slot_on <= 1'b1;
    repeat (10) @(posedge mclk);
    #1;
    chk_bit("slot home", 1'b0, motor_stop);
    results();
  end
endmodule
